/* verilog/rxbc_map.svh */
// Constants for the receive entry sequencer: field widths, mode codes, timing.
// Assumes a 50 MHz system clock; included by the design file only.
// Functional notes
// - Enable synthesizer first, wait for lock, then settle signal processing, then ready.
// - Bit-check measures edge-to-edge intervals against programmable window, bounded count.
// - Two interval checks count as one verified bit.
// - Bit-count select picks 0, 3, 6 or 9 bits: 0, 6, 12, 18 checks.
// - Interval inside window continues; outside window aborts to sleep.
// - Lower and upper limits are six-bit fields of control words 5 and 6.
// - Lower time is limit ticks; upper time is limit minus one ticks.
// - Window counter increments once per window tick while bit-check is active.
// - Fail if counter below lower limit at edge, or on reaching upper limit.
// - Demodulator output ignored during both start-up periods.
// - All selected bits passing enters receiving mode and sets host clock enable.
// - Interrupt on entering receive only when transparent and pattern selects are zero.
// - Transparent select with chip select inactive drives demod stream onto serial out.
// - Transparent select zero stores received data into the data buffer.
// - Host may read buffered receive data at any time during receiving mode.
// - Failed check sleeps sleep value times 1024 base clocks, times 1 or 8.
// - Mode bits 010 select receive polling, 011 continuous receive.
`ifndef RXBC_MAP_SVH
`define RXBC_MAP_SVH
`define RXBC_LIM_W 6
`define RXBC_SLEEP_W 5
`define RXBC_SLEEP_UNIT 1024
`define RXBC_SLEEP_XL 8
`define RXBC_MODE_POLL 3'h2
`define RXBC_MODE_CONT 3'h3
`define RXBC_CHECKS_PER_BIT 2
`define RXBC_BITS_PER_STEP 3
`define RXBC_CLK_MHZ 50
`define RXBC_SETTLE_US 100
`define RXBC_SETTLE_CYC ((`RXBC_SETTLE_US * `RXBC_CLK_MHZ))
`endif

/* verilog/rxbc_pkg.sv */
// Types for the receive entry sequencer.
// Assumes the map header is compiled alongside.
package rxbc_pkg;
  typedef enum logic [2:0] {
    RXBC_IDLE, RXBC_SLEEP, RXBC_SYNTH, RXBC_SETTLE, RXBC_CHECK, RXBC_RECEIVE
  } rxbc_state_t;
endpackage

/* verilog/rxbc_top.sv */
// Receive entry sequencer: start-up, edge-window bit-check, receive routing.
// Assumes synchronous inputs, one 50 MHz clock and a host on the serial side.
`include "rxbc_map.svh"
module rxbc_top #(
  parameter int SLEEP_BASE = `RXBC_SLEEP_UNIT,
  parameter int SETTLE_CYC = `RXBC_SETTLE_CYC,
  parameter int TICK_DIV = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [2:0] op_mode_i,
  input wire logic [`RXBC_LIM_W-1:0] lim_lower_i,
  input wire logic [`RXBC_LIM_W-1:0] lim_upper_i,
  input wire logic [1:0] bit_count_sel_i,
  input wire logic [`RXBC_SLEEP_W-1:0] sleep_value_i,
  input wire logic sleep_ext_i,
  input wire logic transparent_sel_i,
  input wire logic pattern_sel_i,
  input wire logic cs_active_i,
  input wire logic synth_lock_i,
  input wire logic demod_i,
  input wire logic host_clk_clear_i,
  input wire logic irq_clear_i,
  input wire logic buf_ready_i,
  output logic synth_en_o,
  output logic sig_proc_en_o,
  output logic rx_active_o,
  output logic receiving_o,
  output logic host_clk_en_o,
  output logic irq_o,
  output logic serial_out_transparent_pin_o,
  output logic serial_out_oe_o,
  output logic buf_valid_o,
  output logic buf_data_o,
  output logic check_fail_o
);
  import rxbc_pkg::*;

  // ************************************************
  // Reset release
  // ************************************************
  logic rst_s1_r, rst_r;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_r <= rst_s1_r;
    end
  end
  wire logic rst_n = rst_r;

  // ************************************************
  // Window tick divider
  // ************************************************
  // Free-running, so the first tick of a check lands anywhere in one period
  logic [15:0] div_r;
  logic tick;
  assign tick = (div_r == 16'(TICK_DIV - 1));
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) div_r <= 16'h0000;
    else if (tick) div_r <= 16'h0000;
    else div_r <= div_r + 16'h0001;
  end

  // ************************************************
  // Sequencer
  // ************************************************
  rxbc_state_t state_r, state_nxt;
  logic [23:0] timer_r;
  logic [`RXBC_LIM_W-1:0] window_counter_value_r;
  logic [4:0] checks_r;
  logic demod_d_r;
  logic edge_seen;
  logic rx_mode_on;
  logic [4:0] checks_needed;
  logic [23:0] sleep_cycles;
  logic win_low, win_high;

  assign rx_mode_on = (op_mode_i == `RXBC_MODE_POLL) || (op_mode_i == `RXBC_MODE_CONT);
  // three bits per step, two checks per bit
  assign checks_needed = 5'(bit_count_sel_i * `RXBC_BITS_PER_STEP * `RXBC_CHECKS_PER_BIT);
  assign sleep_cycles = 24'(sleep_value_i * SLEEP_BASE * (sleep_ext_i ? `RXBC_SLEEP_XL : 1));
  // edges count only from bit-check on
  assign edge_seen = (state_r == RXBC_CHECK || state_r == RXBC_RECEIVE)
    && (demod_i ^ demod_d_r);
  // below lower at edge, or reaching upper
  // lower time is lim ticks, upper is lim minus one
  assign win_low = edge_seen && (window_counter_value_r < lim_lower_i);
  // Upper limit aborts without waiting for an edge
  assign win_high = (window_counter_value_r >= lim_upper_i);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RXBC_IDLE: if (rx_mode_on) state_nxt = RXBC_SYNTH;
      RXBC_SLEEP: begin
        if (!rx_mode_on) state_nxt = RXBC_IDLE;
        // Exactly sleep_cycles clocks asleep; a zero value still sleeps one clock
        else if (timer_r + 24'h000001 >= sleep_cycles) state_nxt = RXBC_SYNTH;
      end
      RXBC_SYNTH: if (synth_lock_i) state_nxt = RXBC_SETTLE;
      RXBC_SETTLE: begin
        if (timer_r >= 24'(SETTLE_CYC - 1)) begin
          state_nxt = (checks_needed == 5'h00) ? RXBC_RECEIVE : RXBC_CHECK;
        end
      end
      RXBC_CHECK: begin
        if (win_low || win_high) state_nxt = RXBC_SLEEP;
        else if (edge_seen && checks_r == checks_needed - 5'h01) state_nxt = RXBC_RECEIVE;
      end
      RXBC_RECEIVE: if (!rx_mode_on) state_nxt = RXBC_IDLE;
      default: state_nxt = RXBC_IDLE;
    endcase
    if (!rx_mode_on) state_nxt = RXBC_IDLE;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) state_r <= RXBC_IDLE;
    else state_r <= state_nxt;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) timer_r <= 24'h000000;
    else if (state_nxt != state_r) timer_r <= 24'h000000;
    else timer_r <= timer_r + 24'h000001;
  end

  // Tracks demod always, so entering bit-check gives no false edge
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) demod_d_r <= 1'b0;
    else demod_d_r <= demod_i;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      window_counter_value_r <= '0;
      checks_r <= 5'h00;
    end else if (state_r != RXBC_CHECK) begin
      window_counter_value_r <= '0;
      checks_r <= 5'h00;
    end else if (edge_seen) begin
      window_counter_value_r <= '0;
      checks_r <= checks_r + 5'h01;
    end else if (tick) begin
      window_counter_value_r <= window_counter_value_r + 1'b1;
    end
  end

  // ************************************************
  // Outputs and receive routing
  // ************************************************
  logic enter_rx;
  assign enter_rx = (state_nxt == RXBC_RECEIVE) && (state_r != RXBC_RECEIVE);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      synth_en_o <= 1'b0;
      sig_proc_en_o <= 1'b0;
      rx_active_o <= 1'b0;
      receiving_o <= 1'b0;
      check_fail_o <= 1'b0;
    end else begin
      synth_en_o <= (state_nxt != RXBC_IDLE) && (state_nxt != RXBC_SLEEP);
      sig_proc_en_o <= (state_nxt == RXBC_SETTLE) || (state_nxt == RXBC_CHECK)
        || (state_nxt == RXBC_RECEIVE);
      rx_active_o <= (state_nxt != RXBC_IDLE) && (state_nxt != RXBC_SLEEP);
      receiving_o <= (state_nxt == RXBC_RECEIVE);
      check_fail_o <= (state_r == RXBC_CHECK) && (state_nxt == RXBC_SLEEP);
    end
  end

  // host clock enable set on entry; set wins over clear
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) host_clk_en_o <= 1'b0;
    else if (enter_rx) host_clk_en_o <= 1'b1;
    else if (host_clk_clear_i) host_clk_en_o <= 1'b0;
  end

  // interrupt only in buffered, non-pattern mode
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) irq_o <= 1'b0;
    else if (enter_rx && !transparent_sel_i && !pattern_sel_i) irq_o <= 1'b1;
    else if (irq_clear_i) irq_o <= 1'b0;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_transparent_pin_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else begin
      serial_out_oe_o <= (state_r == RXBC_RECEIVE) && transparent_sel_i && !cs_active_i;
      serial_out_transparent_pin_o <= demod_i;
    end
  end

  // Two-entry skid buffer so a stalled reader loses no sample
  // A third edge while full is dropped; legal edge spacing never gets there
  logic [1:0] sb_data_r;
  logic [1:0] sb_cnt_r;
  logic push, pop;
  // buffered path only when not transparent
  assign push = (state_r == RXBC_RECEIVE) && !transparent_sel_i && edge_seen
    && (sb_cnt_r != 2'h2);
  assign pop = buf_valid_o && buf_ready_i;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sb_data_r <= 2'h0;
      sb_cnt_r <= 2'h0;
    end else if (state_r != RXBC_RECEIVE) begin
      sb_cnt_r <= 2'h0;
    end else begin
      if (pop) sb_data_r[0] <= sb_data_r[1];
      if (push) begin
        if (sb_cnt_r == 2'h0 || (sb_cnt_r == 2'h1 && pop)) sb_data_r[0] <= demod_i;
        else sb_data_r[1] <= demod_i;
      end
      sb_cnt_r <= sb_cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      buf_valid_o <= 1'b0;
      buf_data_o <= 1'b0;
    end else begin
      buf_valid_o <= (state_r == RXBC_RECEIVE) && (sb_cnt_r != 2'h0) && !pop;
      buf_data_o <= sb_data_r[0];
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  chk_lock_before_settle: assert property (@(posedge clock_i) disable iff (!rst_n)
    $rose(sig_proc_en_o) |-> $past(synth_lock_i))
    else $error("settle started without lock");
  chk_fail_low_edge: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_r == RXBC_CHECK && rx_mode_on && win_low) |=> state_r == RXBC_SLEEP)
    else $error("short interval not rejected");
  chk_fail_upper_reach: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_r == RXBC_CHECK && rx_mode_on && win_high) |=> state_r == RXBC_SLEEP)
    else $error("upper limit not rejected");
  chk_counter_restart: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_r == RXBC_CHECK && edge_seen) |=> window_counter_value_r == '0)
    else $error("window counter not restarted");
  chk_count_tick: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_r == RXBC_CHECK && state_nxt == RXBC_CHECK && !tick && !edge_seen)
      |=> $stable(window_counter_value_r))
    else $error("counter moved without tick");
  chk_host_clk_set: assert property (@(posedge clock_i) disable iff (!rst_n)
    enter_rx |=> host_clk_en_o)
    else $error("host clock not enabled");
  chk_irq_gate: assert property (@(posedge clock_i) disable iff (!rst_n)
    (enter_rx && (transparent_sel_i || pattern_sel_i) && !irq_o) |=> !irq_o)
    else $error("irq in transparent or pattern mode");
  chk_zero_bits_skip: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_r == RXBC_SETTLE && state_nxt != RXBC_SETTLE && rx_mode_on
      && checks_needed == 5'h00) |=> state_r == RXBC_RECEIVE)
    else $error("zero count did not skip check");
  chk_transparent_oe: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_r == RXBC_RECEIVE && transparent_sel_i && !cs_active_i) |=> serial_out_oe_o)
    else $error("transparent pin not driven");
  chk_synth_first: assert property (@(posedge clock_i) disable iff (!rst_n)
    sig_proc_en_o |-> synth_en_o)
    else $error("signal processing on without synthesizer");
  chk_bit_table: assert property (@(posedge clock_i) disable iff (!rst_n)
    (bit_count_sel_i == 2'h3) |-> checks_needed == 5'h12)
    else $error("nine bits not eighteen checks");
  chk_fail_to_sleep: assert property (@(posedge clock_i) disable iff (!rst_n)
    check_fail_o |-> (state_r == RXBC_SLEEP) && !receiving_o)
    else $error("abort pulse outside sleep");
  chk_counter_bound: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_r == RXBC_CHECK) |-> window_counter_value_r <= lim_upper_i)
    else $error("window counter past upper limit");
  chk_rx_host_clk: assert property (@(posedge clock_i) disable iff (!rst_n)
    $rose(receiving_o) |-> host_clk_en_o)
    else $error("receive without host clock");
  chk_irq_buffered: assert property (@(posedge clock_i) disable iff (!rst_n)
    (enter_rx && !transparent_sel_i && !pattern_sel_i) |=> irq_o)
    else $error("irq missing on buffered entry");
  chk_pin_follows: assert property (@(posedge clock_i) disable iff (!rst_n)
    serial_out_oe_o |-> serial_out_transparent_pin_o == $past(demod_i))
    else $error("transparent pin not following demod");
  chk_buf_bound: assert property (@(posedge clock_i) disable iff (!rst_n)
    sb_cnt_r != 2'h3)
    else $error("buffer count past two");
  chk_sleep_quiet: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_r == RXBC_SLEEP) |-> !synth_en_o && !sig_proc_en_o)
    else $error("circuits on during sleep");
  chk_mode_idle: assert property (@(posedge clock_i) disable iff (!rst_n)
    !rx_mode_on |=> state_r == RXBC_IDLE)
    else $error("non-receive mode not idle");
endmodule

/* verification/rxbc_host_model.sv */
// Host-side reader of the receive buffer: stalls at random, keeps each word taken.
// Assumes the bench seeds $urandom and shares the design clock.
module rxbc_host_model (
  input wire logic clock_i,
  input wire logic buf_valid_i,
  input wire logic buf_data_i,
  output logic buf_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic got[$];
  // ****************
  // Reader
  // ****************
  // reads whenever it likes
  // Random stalls check that no word is lost; with edges 26 to 34 clocks apart the second entry is not reached
  always @(negedge clock_i) buf_ready_o <= ($urandom_range(0, 2) != 0);
  always @(posedge clock_i) begin
    if (buf_valid_i && buf_ready_o) begin
      got.push_back(buf_data_i);
    end
  end
endmodule

/* verification/rx_bit_check_receive_entry_bench.sv */
// Bench for the receive entry sequencer: start-up, bit-check, routing, sleep.
// Assumes short parameters for settle, sleep base and window tick.
module rx_bit_check_receive_entry_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SB = 4;
  localparam int ST = 8;
  localparam int TD = 2;
  logic clk = 0, rst_n = 0, lock = 0, demod = 0, ext = 0, tsel = 0, psel = 0, cs = 0;
  logic hcc = 0, irc = 0, rdy, syn, sp, rxa, rcv, hce, irq, sop, soe, bv, bd, fail;
  logic [2:0] mode = 3'h0;
  logic [5:0] lo = 6'h0A, up = 6'h15;
  logic [1:0] sel = 2'h0;
  logic [4:0] slp = 5'h1;
  int error_cnt = 0, n_checks = 0;
  logic q[$];

  rxbc_top #(.SLEEP_BASE(SB), .SETTLE_CYC(ST), .TICK_DIV(TD)) rxbc_top_i (
    .clock_i(clk), .rst_n_i(rst_n), .op_mode_i(mode), .lim_lower_i(lo), .lim_upper_i(up),
    .bit_count_sel_i(sel), .sleep_value_i(slp), .sleep_ext_i(ext), .transparent_sel_i(tsel),
    .pattern_sel_i(psel), .cs_active_i(cs), .synth_lock_i(lock), .demod_i(demod),
    .host_clk_clear_i(hcc), .irq_clear_i(irc), .buf_ready_i(rdy), .synth_en_o(syn),
    .sig_proc_en_o(sp), .rx_active_o(rxa), .receiving_o(rcv), .host_clk_en_o(hce),
    .irq_o(irq), .serial_out_transparent_pin_o(sop), .serial_out_oe_o(soe),
    .buf_valid_o(bv), .buf_data_o(bd), .check_fail_o(fail));
  rxbc_host_model rxbc_host_model_i (.clock_i(clk), .buf_valid_i(bv), .buf_data_i(bd),
    .buf_ready_o(rdy));

  initial forever #10 clk = ~clk;
  // Synthesizer locks half a cycle after it is enabled
  always @(negedge clk) lock <= syn;

  // ****************
  // Helpers
  // ****************
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic chk_num(input int got, input int exp, input int tol, input string m);
    n_checks++;
    if (got < exp - tol || got > exp + tol) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %0d want %0d", $time, m, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Model of the window in clocks, kept clear of the tick boundaries
  function automatic logic in_win(input int iv);
    return iv >= lo * TD + 2 && iv <= (up - 1) * TD - 3;
  endfunction
  // start-up with noise on the demodulator until the last settle clock
  task automatic start(input logic [2:0] m);
    int k = 0;
    mode = m;
    while (sp !== 1'b1 && k < 200) begin
      tick(1);
      demod = ~demod;
      k++;
    end
    chk_bit(syn, 1'b1, "synth off");
    repeat (ST - 2) begin
      tick(1);
      demod = ~demod;
    end
    tick(2);
  endtask
  // edge train, each interval measured alone
  task automatic edges(input int n, input int iv);
    repeat (n) begin
      tick(iv);
      demod = ~demod;
    end
  endtask

  // ****************
  // Tests
  // ****************
  task automatic pass_run(input logic [1:0] s, input logic [2:0] m, input int iv);
    int n = 6 * s;
    sel = s;
    tsel = $urandom_range(0, 1);
    psel = $urandom_range(0, 1);
    start(m);
    if (n > 0) edges(n - 1, iv);
    tick(3);
    chk_bit(rcv, n == 0, "receive count");
    if (n > 0) edges(1, iv);
    tick(3);
    chk_bit(rcv, in_win(iv), "receive entry");
    chk_bit(hce, 1'b1, "host clock");
    chk_bit(irq, !tsel && !psel, "irq");
    chk_bit(rxa, 1'b1, "rx active");
    if (tsel) begin
      repeat (4) begin
        edges(1, 2);
        tick(1);
        chk_bit(soe, 1'b1, "pin drive");
        chk_bit(sop, demod, "pin level");
      end
      cs = 1'b1;
      tick(2);
      chk_bit(soe, 1'b0, "pin released");
      cs = 1'b0;
    end else begin
      rxbc_host_model_i.got.delete();
      q.delete();
      repeat (3) begin
        edges(1, iv);
        q.push_back(demod);
      end
      tick(20);
      chk_num(rxbc_host_model_i.got.size(), 3, 0, "buffer count");
      for (int i = 0; i < 3 && i < rxbc_host_model_i.got.size(); i++) begin
        chk_bit(rxbc_host_model_i.got[i], q[i], "buffer bit");
      end
    end
    hcc = 1'b1;
    irc = 1'b1;
    mode = 3'h0;
    tick(1);
    hcc = 1'b0;
    irc = 1'b0;
    tick(3);
    chk_bit(irq, 1'b0, "irq clear");
    chk_bit(hce, 1'b0, "host clock clear");
    $display("pass run sel %0d mode %0d done", s, m);
  endtask
  // short edge or missing edge aborts, then sleep
  task automatic fail_run(input int iv, input int nok);
    int k = 0;
    sel = 2'h3;
    slp = $urandom_range(1, 4);
    ext = $urandom_range(0, 1);
    start(3'h2);
    edges(nok, 30);
    if (iv > 0) edges(1, iv);
    while (fail !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    chk_bit(fail, 1'b1, "no abort");
    chk_bit(rcv, 1'b0, "receive after abort");
    chk_bit(sp, 1'b0, "sleep proc");
    chk_bit(rxa, 1'b0, "sleep active");
    k = 0;
    while (syn !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    chk_num(k, slp * SB * (ext ? 8 : 1), 0, "sleep length");
    mode = 3'h0;
    tick(4);
    $display("fail run interval %0d done", iv);
  endtask

  initial begin
    void'($urandom(32'h6997CF37));
    tick(5);
    rst_n = 1'b1;
    tick(4);
    mode = 3'h1;
    tick(4);
    chk_bit(syn, 1'b0, "other mode idle");
    // both receive modes, every bit count
    for (int i = 0; i < 8; i++) begin
      // legal limits, window near edge spacing
      lo = $urandom_range(10, 12);
      up = $urandom_range(20, 22);
      pass_run(2'(i), i[2] ? 3'h2 : 3'h3, $urandom_range(26, 34));
    end
    fail_run(8, 2);
    fail_run(0, 3);
    report_and_stop();
  end
  initial begin
    tick(30000);
    error_cnt++;
    report_and_stop();
  end
endmodule
